// file: hdl/alarm_pkg.sv
// Constants and encodings shared by the servo alarm manager files
package alarm_pkg;

    // ========================================================
    // Alarm slots
    localparam int N_ALM   = 11;
    localparam int A_HEAT  = 0;
    localparam int A_LOWV  = 1;
    localparam int A_LIM   = 2;
    localparam int A_NEG   = 3;
    localparam int A_POS   = 4;
    localparam int A_CUR   = 5;
    localparam int A_SAVE  = 6;
    localparam int A_CMD   = 7;
    localparam int A_IO    = 8;
    localparam int A_PROG  = 9;
    localparam int A_ESTOP = 10;

    // ========================================================
    // Alarm classes, one bit per slot
    localparam logic [N_ALM-1:0] RESET_OK   = 11'h6ff;
    localparam logic [N_ALM-1:0] FAULT_MASK = 11'h003;
    localparam logic [N_ALM-1:0] ALM_RST    = 11'h000;

    // Display codes as two BCD digits, slot 10 first
    localparam logic [N_ALM-1:0][7:0] ALM_CODE = {
        8'h27, 8'h53, 8'h42, 8'h24, 8'h18, 8'h16,
        8'h15, 8'h14, 8'h13, 8'h11, 8'h01
    };
    localparam logic [7:0] DISP_IDLE = 8'h00;

    // ========================================================
    // Pin inputs
    localparam int NPIN   = 13;
    localparam int P_HEAT = 0;
    localparam int P_LOWV = 1;
    localparam int P_LIM  = 2;
    localparam int P_NEG  = 3;
    localparam int P_POS  = 4;
    localparam int P_CUR  = 5;
    localparam int P_SAVE = 6;
    localparam int P_CMD  = 7;
    localparam int P_IO   = 8;
    localparam int P_PROG = 9;
    localparam int P_STOP = 10;
    localparam int P_CLR  = 11;
    localparam int P_EN   = 12;
    localparam logic [NPIN-1:0] PIN_RST = 13'h0000;

    // ========================================================
    // Blink timing
    localparam int CLK_MHZ      = 125;
    localparam int BLINK_MS     = 250;
    localparam int BLINK_CYC    = BLINK_MS * CLK_MHZ * 1000;
    localparam int CNT_W        = 25;

endpackage

// file: hdl/alarm_if.sv
// Latched alarm set passed from the manager to the display driver
interface alarm_if
    import alarm_pkg::*;
    ();
    logic [N_ALM-1:0] latched;
    logic             any;

    modport mgr  (output latched, output any);
    modport disp (input  latched, input  any);
endinterface

// file: hdl/alarm_display.sv
// Blinking front display driver for the active alarm code
module alarm_display
    import alarm_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    alarm_if.disp           a,
    output logic [7:0]      disp_code,
    output logic            disp_lit
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             phase;
        logic [7:0]       code;
        logic             lit;
    } disp_state_t;

    disp_state_t q_ff;
    disp_state_t nxt_q;
    logic [7:0]  sel;

    // ========================================================
    // Selection and blink
    // Lowest slot wins, so faults always show ahead of warnings
    always_comb begin
        sel = DISP_IDLE;
        for (int i = N_ALM - 1; i >= 0; i--) begin
            if (a.latched[i]) begin
                sel = ALM_CODE[i];
            end
        end
        nxt_q = q_ff;
        if (!a.any) begin
            nxt_q.cnt   = '0;
            nxt_q.phase = 1'b1;
            nxt_q.code  = DISP_IDLE;
            nxt_q.lit   = 1'b0;
        end else begin
            if (q_ff.cnt == CNT_W'(BLINK_CYCLES - 1)) begin
                nxt_q.cnt   = '0;
                nxt_q.phase = ~q_ff.phase;
            end else begin
                nxt_q.cnt = q_ff.cnt + CNT_W'(1);
            end
            nxt_q.code = sel;
            nxt_q.lit  = nxt_q.phase;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q_ff <= '{cnt: '0, phase: 1'b1, code: DISP_IDLE, lit: 1'b0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign disp_code = q_ff.code;
    assign disp_lit  = q_ff.lit;

    // ========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_dark_when_idle:
        assert property (!a.any |=> !disp_lit && disp_code == DISP_IDLE)
        else $error("display lit with no alarm");

    a_blink_toggle:
        assert property (a.any && $past(a.any) &&
                         q_ff.cnt == CNT_W'(BLINK_CYCLES - 1)
                         |=> disp_lit != $past(disp_lit))
        else $error("display did not toggle at blink edge");

    a_steady_between:
        assert property (a.any && $past(a.any) &&
                         q_ff.cnt != CNT_W'(BLINK_CYCLES - 1)
                         |=> $stable(disp_lit))
        else $error("display changed between blink edges");

    c_blink_seen:
        cover property (a.any ##1 disp_lit ##1 disp_lit[*2]);

endmodule

// file: hdl/servo_alarm_manager.sv
// Servo drive alarm manager: latching, classes, reactions, display
//
// Overview of operation
// - Active alarm code blinks on front display
// - Heat-sink overtemperature is resettable fault, servo off
// - Low supply voltage is resettable fault, servo off
// - Code 13 limit warning stops all rotation
// - Code 14 negative limit blocks reverse motion
// - Code 15 positive limit blocks forward motion
// - Motion command while disabled raises code 24
// - Emergency stop decelerates, keeps servo power
// - Missing motion program raises code 53
// - Code 42 unassigned IO warning, not resettable
// - Codes 16 and 18 only warn, resettable
module servo_alarm_manager
    import alarm_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             heat_over,
    input  wire logic             supply_low,
    input  wire logic             limit_any,
    input  wire logic             limit_neg,
    input  wire logic             limit_pos,
    input  wire logic             current_limit,
    input  wire logic             save_fail,
    input  wire logic             motion_cmd,
    input  wire logic             io_unassigned,
    input  wire logic             program_absent,
    input  wire logic             estop,
    input  wire logic             clear_req,
    input  wire logic             enable_req,
    output logic                  servo_en,
    output logic                  inhibit_fwd,
    output logic                  inhibit_rev,
    output logic                  decel_stop,
    output logic                  fault_active,
    output logic [N_ALM-1:0]      alarm_flags,
    output logic [7:0]            disp_code,
    output logic                  disp_lit
);

    typedef struct packed {
        logic [NPIN-1:0]  s1;
        logic [NPIN-1:0]  s2;
        logic             clr_d;
        logic [N_ALM-1:0] latched;
        logic             servo_en;
        logic             inh_fwd;
        logic             inh_rev;
        logic             decel;
        logic             fault;
    } mgr_state_t;

    mgr_state_t       q_ff;
    mgr_state_t       nxt_q;
    logic [NPIN-1:0]  pins;
    logic [N_ALM-1:0] det;
    logic [N_ALM-1:0] nxt_latched;
    logic             clr_pulse;

    alarm_if alm ();

    // ========================================================
    // Pin gathering
    assign pins = {enable_req, clear_req, estop, program_absent,
                   io_unassigned, motion_cmd, save_fail, current_limit,
                   limit_pos, limit_neg, limit_any, supply_low,
                   heat_over};

    // ========================================================
    // Detection
    // All detectors come from synchronised pins; code 24 is also gated by the registered servo_en
    assign det[A_HEAT]  = q_ff.s2[P_HEAT];
    assign det[A_LOWV]  = q_ff.s2[P_LOWV];
    assign det[A_LIM]   = q_ff.s2[P_LIM];
    assign det[A_NEG]   = q_ff.s2[P_NEG];
    assign det[A_POS]   = q_ff.s2[P_POS];
    assign det[A_CUR]   = q_ff.s2[P_CUR];
    assign det[A_SAVE]  = q_ff.s2[P_SAVE];
    assign det[A_CMD]   = q_ff.s2[P_CMD] & ~q_ff.servo_en;
    assign det[A_IO]    = q_ff.s2[P_IO];
    assign det[A_PROG]  = q_ff.s2[P_PROG];
    assign det[A_ESTOP] = q_ff.s2[P_STOP];

    // Rising edge only, so a held button clears once
    assign clr_pulse = q_ff.s2[P_CLR] & ~q_ff.clr_d;

    // ========================================================
    // Per-slot latches
    // A new detection wins over a clear in the same cycle
    for (genvar i = 0; i < N_ALM; i++) begin : g_latch
        assign nxt_latched[i] = det[i] |
            (q_ff.latched[i] & ~(clr_pulse & RESET_OK[i]));
    end

    // ========================================================
    // State update
    always_comb begin
        nxt_q         = q_ff;
        nxt_q.s1      = pins;
        nxt_q.s2      = q_ff.s1;
        nxt_q.clr_d   = q_ff.s2[P_CLR];
        nxt_q.latched = nxt_latched;
        nxt_q.fault   = |(nxt_latched & FAULT_MASK);
        // Servo power is cut only by faults; warnings leave it
        nxt_q.servo_en = q_ff.s2[P_EN] & ~nxt_q.fault;
        nxt_q.inh_fwd  = nxt_latched[A_LIM] | nxt_latched[A_POS];
        nxt_q.inh_rev  = nxt_latched[A_LIM] | nxt_latched[A_NEG];
        nxt_q.decel    = nxt_latched[A_ESTOP];
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q_ff <= '{s1: PIN_RST, s2: PIN_RST, clr_d: 1'b0,
                      latched: ALM_RST, servo_en: 1'b0,
                      inh_fwd: 1'b0, inh_rev: 1'b0, decel: 1'b0,
                      fault: 1'b0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ========================================================
    // Outputs and display
    assign servo_en     = q_ff.servo_en;
    assign inhibit_fwd  = q_ff.inh_fwd;
    assign inhibit_rev  = q_ff.inh_rev;
    assign decel_stop   = q_ff.decel;
    assign fault_active = q_ff.fault;
    assign alarm_flags  = q_ff.latched;

    assign alm.latched = q_ff.latched;
    assign alm.any     = |q_ff.latched;

    alarm_display #(
        .BLINK_CYCLES (BLINK_CYCLES)
    ) u_display (
        .core_clk  (core_clk),
        .reset     (reset),
        .a         (alm.disp),
        .disp_code (disp_code),
        .disp_lit  (disp_lit)
    );

    // ========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_heat_cuts_servo:
        assert property (q_ff.s2[P_HEAT] |=> !servo_en && fault_active
                         && alarm_flags[A_HEAT])
        else $error("heat fault did not cut servo");

    a_heat_clears:
        assert property (alarm_flags[A_HEAT] && clr_pulse &&
                         !q_ff.s2[P_HEAT] |=> !alarm_flags[A_HEAT])
        else $error("heat fault not cleared by request");

    a_lowv_cuts_servo:
        assert property (q_ff.s2[P_LOWV] |=> !servo_en && fault_active)
        else $error("low voltage fault did not cut servo");

    a_fault_holds_off:
        assert property ((alarm_flags & FAULT_MASK) != '0
                         |-> !servo_en)
        else $error("servo on while a fault is latched");

    a_limit_stops_all:
        assert property (alarm_flags[A_LIM] |-> inhibit_fwd &&
                         inhibit_rev)
        else $error("general limit did not stop rotation");

    a_neg_blocks_rev:
        assert property (q_ff.s2[P_NEG] |=> inhibit_rev &&
                         alarm_flags[A_NEG])
        else $error("negative limit did not block reverse");

    a_pos_blocks_fwd:
        assert property (q_ff.s2[P_POS] |=> inhibit_fwd &&
                         alarm_flags[A_POS])
        else $error("positive limit did not block forward");

    a_cmd_while_off:
        assert property (q_ff.s2[P_CMD] && !servo_en
                         |=> alarm_flags[A_CMD])
        else $error("command while disabled not flagged");

    a_estop_keeps_power:
        assert property (decel_stop && !fault_active
                         |-> servo_en == $past(q_ff.s2[P_EN]))
        else $error("emergency stop changed servo power");

    a_prog_missing:
        assert property (q_ff.s2[P_PROG] |=> alarm_flags[A_PROG])
        else $error("missing program not flagged");

    a_io_stays_latched:
        assert property (alarm_flags[A_IO] |=> alarm_flags[A_IO])
        else $error("unassigned io warning was cleared");

    a_warn_no_fault:
        assert property (fault_active == (alarm_flags[A_HEAT] |
                                          alarm_flags[A_LOWV]))
        else $error("warning counted as a fault");

    a_clear_resettable:
        assert property (clr_pulse && q_ff.s2[P_CUR:P_LIM] == '0 &&
                         !q_ff.s2[P_SAVE] |=> alarm_flags[A_SAVE:A_LIM]
                         == '0)
        else $error("resettable warnings survived a clear");

    // ========================================================
    // Reaction and latch checks
    a_lowv_clears:
        assert property (alarm_flags[A_LOWV] && clr_pulse &&
                         !q_ff.s2[P_LOWV] |=> !alarm_flags[A_LOWV])
        else $error("low voltage fault not cleared by request");

    a_heat_needs_pin:
        assert property (!q_ff.s2[P_HEAT] && !alarm_flags[A_HEAT]
                         |=> !alarm_flags[A_HEAT])
        else $error("heat fault raised with no detection");

    a_lowv_needs_pin:
        assert property (!q_ff.s2[P_LOWV] && !alarm_flags[A_LOWV]
                         |=> !alarm_flags[A_LOWV])
        else $error("low voltage fault raised with no detection");

    // Warnings must not touch servo power; only the fault mask may
    a_warn_keeps_power:
        assert property ((alarm_flags & FAULT_MASK) == '0
                         |-> servo_en == $past(q_ff.s2[P_EN]))
        else $error("warning changed servo power");

    a_lim_blocks:
        assert property (q_ff.s2[P_LIM] |=> inhibit_fwd && inhibit_rev
                         && alarm_flags[A_LIM])
        else $error("general limit not latched");

    a_fwd_only_limits:
        assert property (inhibit_fwd |-> alarm_flags[A_LIM] ||
                         alarm_flags[A_POS])
        else $error("forward blocked with no limit latched");

    a_rev_only_limits:
        assert property (inhibit_rev |-> alarm_flags[A_LIM] ||
                         alarm_flags[A_NEG])
        else $error("reverse blocked with no limit latched");

    a_cmd_on_quiet:
        assert property (q_ff.s2[P_CMD] && servo_en &&
                         !alarm_flags[A_CMD] |=> !alarm_flags[A_CMD])
        else $error("command while enabled was flagged");

    a_estop_decel:
        assert property (q_ff.s2[P_STOP] |=> decel_stop)
        else $error("emergency stop did not decelerate");

    a_io_flagged:
        assert property (q_ff.s2[P_IO] |=> alarm_flags[A_IO])
        else $error("unassigned io not flagged");

    a_cur_flagged:
        assert property (q_ff.s2[P_CUR] |=> alarm_flags[A_CUR])
        else $error("current limit not flagged");

    a_save_flagged:
        assert property (q_ff.s2[P_SAVE] |=> alarm_flags[A_SAVE])
        else $error("save failure not flagged");

    // Without a clear edge no latched alarm may fall on its own
    a_no_silent_drop:
        assert property (!clr_pulse |=>
                         ($past(alarm_flags) & ~alarm_flags) == '0)
        else $error("alarm dropped without a clear");

    a_late_clears:
        assert property (clr_pulse && !q_ff.s2[P_CMD] &&
                         !q_ff.s2[P_PROG] && !q_ff.s2[P_STOP]
                         |=> !alarm_flags[A_CMD] && !alarm_flags[A_PROG]
                         && !alarm_flags[A_ESTOP])
        else $error("late warnings survived a clear");

    a_clear_once:
        assert property (clr_pulse |=> !clr_pulse)
        else $error("held clear acted twice");

    c_fault_seen:
        cover property (q_ff.s2[P_HEAT] ##1 !servo_en);
    c_estop_seen:
        cover property (servo_en ##1 decel_stop && servo_en);
    c_clear_seen:
        cover property (alarm_flags[A_LIM] && clr_pulse
                        ##1 !alarm_flags[A_LIM]);
    c_cmd_seen:
        cover property (q_ff.s2[P_CMD] && !servo_en ##1 alarm_flags[A_CMD]);

endmodule

// file: tb/operator_model.sv
// Operator and motion controller model facing the alarm manager
module operator_model (
    input  wire logic        core_clk,
    input  wire logic        want_en,
    input  wire logic        want_move,
    input  wire logic        want_clear,
    input  wire logic        disp_lit,
    output logic             enable_req,
    output logic             motion_cmd,
    output logic             clear_req,
    output logic [15:0]      blink_edges
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        lit_seen = 1'b0;
    logic [15:0] edge_cnt = 16'h0000;

    // ========================================================
    // Requests
    // Passed straight through so they move only when the bench moves them
    assign enable_req = want_en;
    assign motion_cmd = want_move;
    assign clear_req  = want_clear;

    // ========================================================
    // Display watcher
    // The operator only sees transitions, so count them
    assign blink_edges = edge_cnt;
    always @(posedge core_clk) begin
        lit_seen <= disp_lit;
        if (disp_lit !== lit_seen) begin
            edge_cnt <= edge_cnt + 16'h0001;
        end
    end
endmodule

// file: tb/tb_servo_alarm_manager.sv
// Self-checking bench for the servo alarm manager
module tb_servo_alarm_manager
    import alarm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BLINK = 8;
    localparam int LIMIT = 4000;

    logic             core_clk   = 1'b0;
    logic             reset      = 1'b1;
    logic [NPIN-1:0]  pin        = PIN_RST;
    logic             want_en    = 1'b0;
    logic             want_move  = 1'b0;
    logic             want_clear = 1'b0;
    logic             enable_req;
    logic             motion_cmd;
    logic             clear_req;
    logic             servo_en;
    logic             inhibit_fwd;
    logic             inhibit_rev;
    logic             decel_stop;
    logic             fault_active;
    logic [N_ALM-1:0] alarm_flags;
    logic [7:0]       disp_code;
    logic             disp_lit;
    logic [15:0]      blink_edges;
    int               err_total   = 0;
    int               comparisons = 0;
    int               cycles      = 0;

    always #4 core_clk = ~core_clk;

    servo_alarm_manager #(.BLINK_CYCLES(BLINK)) u_servo_alarm_manager (
        .core_clk(core_clk), .reset(reset),
        .heat_over(pin[P_HEAT]), .supply_low(pin[P_LOWV]),
        .limit_any(pin[P_LIM]), .limit_neg(pin[P_NEG]),
        .limit_pos(pin[P_POS]), .current_limit(pin[P_CUR]),
        .save_fail(pin[P_SAVE]), .motion_cmd(motion_cmd),
        .io_unassigned(pin[P_IO]), .program_absent(pin[P_PROG]),
        .estop(pin[P_STOP]), .clear_req(clear_req),
        .enable_req(enable_req), .servo_en(servo_en),
        .inhibit_fwd(inhibit_fwd), .inhibit_rev(inhibit_rev),
        .decel_stop(decel_stop), .fault_active(fault_active),
        .alarm_flags(alarm_flags), .disp_code(disp_code),
        .disp_lit(disp_lit)
    );

    operator_model u_operator_model (
        .core_clk(core_clk), .want_en(want_en), .want_move(want_move),
        .want_clear(want_clear), .disp_lit(disp_lit),
        .enable_req(enable_req), .motion_cmd(motion_cmd),
        .clear_req(clear_req), .blink_edges(blink_edges)
    );

    // ========================================================
    // Compare and helper tasks
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input logic [N_ALM-1:0] got,
                             input logic [N_ALM-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic do_reset();
        pin = PIN_RST;
        want_move = 1'b0;
        want_clear = 1'b0;
        reset = 1'b1;
        step(3);
        chk_code(disp_code, DISP_IDLE);
        chk_flags(alarm_flags, '0);
        reset = 1'b0;
    endtask

    // Clear acts on a rising edge, so it must drop again before the next
    task automatic pulse_clear();
        want_clear = 1'b1;
        step(5);
        want_clear = 1'b0;
        step(2);
    endtask

    // ========================================================
    // Scenarios
    // how = {fwd, rev, fault, decel, resettable}
    task automatic run_alarm(input int p, input int s,
                             input logic [7:0] code, input logic [4:0] how);
        logic [N_ALM-1:0] exp;
        logic [15:0]      n;
        exp = '0;
        exp[s] = 1'b1;
        pin[p] = 1'b1;
        step(3);
        chk_flags(alarm_flags, exp);
        chk_bit(servo_en, !how[2]);
        chk_bit(fault_active, how[2]);
        chk_bit(inhibit_fwd, how[4]);
        chk_bit(inhibit_rev, how[3]);
        chk_bit(decel_stop, how[1]);
        step(1);
        chk_code(disp_code, code);
        chk_bit(disp_lit, 1'b1);
        n = blink_edges;
        step(3 * BLINK);
        chk_bit((blink_edges - n) >= 16'h0002, 1'b1);
        pulse_clear();
        chk_flags(alarm_flags, exp);
        pin[p] = 1'b0;
        step(3);
        chk_bit(servo_en, !how[2]);
        pulse_clear();
        chk_flags(alarm_flags, how[0] ? '0 : exp);
        chk_bit(servo_en, 1'b1);
        chk_code(disp_code, how[0] ? DISP_IDLE : code);
        if (!how[0]) begin
            do_reset();
        end
    endtask

    task automatic t_classes();
        run_alarm(P_HEAT, A_HEAT, ALM_CODE[A_HEAT], 5'b00101);
        run_alarm(P_LOWV, A_LOWV, ALM_CODE[A_LOWV], 5'b00101);
        run_alarm(P_LIM, A_LIM, 8'h13, 5'b11001);
        run_alarm(P_NEG, A_NEG, 8'h14, 5'b01001);
        run_alarm(P_POS, A_POS, 8'h15, 5'b10001);
        run_alarm(P_CUR, A_CUR, 8'h16, 5'b00001);
        run_alarm(P_SAVE, A_SAVE, 8'h18, 5'b00001);
        run_alarm(P_PROG, A_PROG, 8'h53, 5'b00001);
        run_alarm(P_STOP, A_ESTOP, ALM_CODE[A_ESTOP], 5'b00011);
        run_alarm(P_IO, A_IO, 8'h42, 5'b00000);
    endtask

    task automatic t_cmd24();
        logic [N_ALM-1:0] exp;
        exp = '0;
        exp[A_CMD] = 1'b1;
        want_en = 1'b0;
        step(4);
        want_move = 1'b1;
        step(3);
        chk_flags(alarm_flags, exp);
        chk_bit(servo_en, 1'b0);
        want_move = 1'b0;
        pulse_clear();
        chk_flags(alarm_flags, '0);
        want_en = 1'b1;
        step(4);
        want_move = 1'b1;
        step(4);
        chk_flags(alarm_flags, '0);
        want_move = 1'b0;
    endtask

    // A resettable fault and a sticky warning together
    task automatic t_mixed();
        logic [N_ALM-1:0] exp;
        exp = '0;
        exp[A_IO] = 1'b1;
        pin[P_HEAT] = 1'b1;
        pin[P_IO] = 1'b1;
        step(4);
        chk_code(disp_code, ALM_CODE[A_HEAT]);
        pin = PIN_RST;
        pulse_clear();
        chk_flags(alarm_flags, exp);
        chk_bit(servo_en, 1'b1);
        chk_code(disp_code, 8'h42);
        do_reset();
        chk_flags(alarm_flags, '0);
    endtask

    // ========================================================
    // Run control
    task automatic conclude();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run is well under a thousand cycles; a hang ends here
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        @(negedge core_clk);
        do_reset();
        want_en = 1'b1;
        step(4);
        chk_bit(servo_en, 1'b1);
        t_classes();
        t_cmd24();
        t_mixed();
        conclude();
    end
endmodule
